// [design/mtc_parser.sv]
// Machine control parser: decodes received frames into transport state,
// and sends all-call commands for local key and shuttle events.
// Assumes one received byte per rx_valid pulse, synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// R1 - System reset byte restarts receiver and clears running status.
// R2 - Frames are F0, 7F, device id, 06, command, operands, F7.
// R3 - Device id 00 to 7E addresses one unit, 7F calls all.
// R4 - Act only as slave and when id is ours or all-call.
// R5 - Stop key sends all-call stop command 01.
// R6 - Accepted stop command halts the transport.
// R7 - Accepted play or deferred play starts playback.
// R8 - Play key sends all-call deferred play command 03.
// R9 - Fast forward key or shuttle right sends all-call command 04.
// R10 - Accepted fast forward starts fast-forward movement.
// R11 - Rewind key or shuttle left sends all-call command 05.
// R12 - Accepted rewind starts rewind movement.
// R13 - Record strobe while stopped begins recording.
// R14 - Record strobe while playing punches in.
// R15 - Record exit while recording punches out, else no effect.
// R16 - Song load done sends all-call machine control reset 0D.
// R17 - Accepted machine control reset restores power-on settings.
// R18 - Accepted write stores operand data into the named field.
// R19 - Write carries byte count then name and data pairs until F7.
// R20 - After active sensing, 300 ms silence clears receiver state.
// R21 - Data bytes have bit 7 clear; status other than real-time F8 to FE aborts the frame.
// R22 - Foreign ids and unsupported commands are ignored.
module mtc_parser
    import mtc_pkg::*;
#(
    parameter int SENSE_CYCLES = SENSE_CYC
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic slave_mode,
    input wire logic [6:0] own_id,
    input wire logic key_stop,
    input wire logic key_play,
    input wire logic key_ffwd,
    input wire logic key_rew,
    input wire logic shuttle_cue,
    input wire logic shuttle_review,
    input wire logic song_loaded,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output mtc_pkg::mtc_tr_e transport,
    output logic punch_in,
    output logic punch_out,
    output logic field_we,
    output logic [6:0] field_name,
    output logic [6:0] field_data,
    output logic rx_reinit,
    output logic [7:0] running_status
);
    import mtc_pkg::*;

    mtc_rx_e rx_st;
    logic [7:0] cmd;
    logic addressed;
    logic [6:0] remain;
    logic sense_armed;
    logic [31:0] sense_cnt;
    logic sense_timeout;
    logic is_status;
    logic is_rt;
    logic frame_ok;
    logic accept;
    logic [4:0] pend;
    logic [4:0] prev_keys;
    logic [4:0] key_now;
    logic [7:0] tx_cmd;

    mtc_tx_if txc ();

    function automatic logic supported(input logic [7:0] c);
        return c == CMD_STOP || c == CMD_PLAY || c == CMD_DPLAY || c == CMD_FFWD ||
            c == CMD_REW || c == CMD_RSTROBE || c == CMD_REXIT || c == CMD_MRESET ||
            c == CMD_WRITE;
    endfunction : supported

    assign is_status = rx_valid && rx_data[7];
    // Real-time bytes other than system reset FF may interleave anywhere without breaking a frame
    assign is_rt = is_status && rx_data >= RT_FIRST;
    assign sense_timeout = sense_armed && sense_cnt >= 32'(SENSE_CYCLES - 1);
    // Simple commands take effect at F7 only, so a cut frame has no effect
    assign frame_ok = rx_valid && rx_data == SYX_END && rx_st == RX_TAIL;
    // R4 slave and address check
    assign accept = frame_ok && slave_mode && addressed;
    assign rx_reinit = (rx_valid && rx_data == SYS_RESET) || sense_timeout;

    // R2 frame walk
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_st <= RX_IDLE;
            cmd <= 8'h00;
            addressed <= 1'b0;
            remain <= 7'h00;
        end
        // R1 system reset
        else if (rx_reinit)
        begin
            rx_st <= RX_IDLE;
        end
        else if (is_status && !is_rt)
        begin
            // R21 status aborts frame
            rx_st <= (rx_data == SYX_START) ? RX_UNIV : RX_IDLE;
        end
        else if (rx_valid && !is_rt)
        begin
            case (rx_st)
                RX_UNIV: rx_st <= (rx_data == RT_UNIV_ID) ? RX_DEV : RX_IDLE;
                RX_DEV:
                begin
                    // R3 all-call or own number
                    addressed <= rx_data == ALL_CALL || rx_data[6:0] == own_id;
                    rx_st <= RX_SUB;
                end
                RX_SUB: rx_st <= (rx_data == MCC_SUB_ID) ? RX_CMD : RX_SKIP;
                RX_CMD:
                begin
                    cmd <= rx_data;
                    // R22 unsupported ignored
                    if (!supported(rx_data))
                    begin
                        rx_st <= RX_SKIP;
                    end
                    else
                    begin
                        rx_st <= (rx_data == CMD_WRITE) ? RX_COUNT : RX_TAIL;
                    end
                end
                RX_COUNT:
                begin
                    // R19 byte count
                    remain <= rx_data[6:0];
                    rx_st <= (rx_data[6:0] == 7'h00) ? RX_TAIL : RX_NAME;
                end
                RX_NAME:
                begin
                    remain <= remain - 7'h01;
                    rx_st <= (remain == 7'h01) ? RX_TAIL : RX_DATA;
                end
                RX_DATA:
                begin
                    remain <= remain - 7'h01;
                    rx_st <= (remain == 7'h01) ? RX_TAIL : RX_NAME;
                end
                default: rx_st <= rx_st;
            endcase
        end
    end

    // R18 field write
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            field_we <= 1'b0;
            field_name <= 7'h00;
            field_data <= 7'h00;
        end
        else
        begin
            field_we <= 1'b0;
            if (rx_valid && !rx_data[7] && !rx_reinit && slave_mode && addressed)
            begin
                if (rx_st == RX_NAME)
                begin
                    field_name <= rx_data[6:0];
                end
                // R19 each data byte follows its name
                if (rx_st == RX_DATA)
                begin
                    field_data <= rx_data[6:0];
                    field_we <= 1'b1;
                end
            end
        end
    end

    // R1 running status tracking
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            running_status <= 8'h00;
        end
        else if (rx_reinit)
        begin
            running_status <= 8'h00;
        end
        else if (is_status && !is_rt)
        begin
            running_status <= (rx_data < SYX_START) ? rx_data : 8'h00;
        end
    end

    // R20 sensing watchdog
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sense_armed <= 1'b0;
            sense_cnt <= 32'h0;
        end
        else if (rx_valid && rx_data == SYS_RESET)
        begin
            sense_armed <= 1'b0;
            sense_cnt <= 32'h0;
        end
        else if (rx_valid)
        begin
            sense_armed <= sense_armed || rx_data == ACT_SENSE;
            sense_cnt <= 32'h0;
        end
        else if (sense_timeout)
        begin
            sense_cnt <= 32'h0;
        end
        else if (sense_armed)
        begin
            sense_cnt <= sense_cnt + 32'h1;
        end
    end

    // Transport state machine
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            transport <= TR_STOP;
            punch_in <= 1'b0;
            punch_out <= 1'b0;
        end
        else
        begin
            punch_in <= 1'b0;
            punch_out <= 1'b0;
            if (accept)
            begin
                case (cmd)
                    // R6 stop
                    CMD_STOP: transport <= TR_STOP;
                    // R7 play and deferred play
                    CMD_PLAY, CMD_DPLAY: transport <= TR_PLAY;
                    // R10 fast forward
                    CMD_FFWD: transport <= TR_FFWD;
                    // R12 rewind
                    CMD_REW: transport <= TR_REW;
                    CMD_RSTROBE:
                    begin
                        // R13 record from stop
                        if (transport == TR_STOP)
                        begin
                            transport <= TR_REC;
                        end
                        // R14 punch-in
                        else if (transport == TR_PLAY)
                        begin
                            transport <= TR_REC;
                            punch_in <= 1'b1;
                        end
                    end
                    // R15 punch-out
                    CMD_REXIT:
                    begin
                        if (transport == TR_REC)
                        begin
                            transport <= TR_PLAY;
                            punch_out <= 1'b1;
                        end
                    end
                    // R17 power-on settings
                    CMD_MRESET: transport <= TR_STOP;
                    default: transport <= transport;
                endcase
            end
        end
    end

    // Local events latch until the sequencer takes them; one frame at a time
    assign key_now = {song_loaded, key_rew | shuttle_review, key_ffwd | shuttle_cue,
        key_play, key_stop};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_keys <= 5'h00;
            pend <= 5'h00;
        end
        else
        begin
            prev_keys <= key_now;
            // Set wins over the clear of the same bit
            pend <= (pend & ~(txc.req && !txc.busy ? (pend & -pend) : 5'h00))
                | (key_now & ~prev_keys);
        end
    end

    // R5 R8 R9 R11 R16 command choice, lowest pending bit first
    assign tx_cmd = pend[0] ? CMD_STOP : pend[1] ? CMD_DPLAY : pend[2] ? CMD_FFWD :
        pend[3] ? CMD_REW : CMD_MRESET;

    assign txc.req = pend != 5'h00;
    assign txc.cmd = tx_cmd;

    mtc_tx_seq u_tx (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .cmd_port(txc),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .tx_ready(tx_ready)
    );

    sequence strobe_frame;
        accept && cmd == CMD_RSTROBE && transport == TR_PLAY;
    endsequence

    punch_in_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        strobe_frame |=> punch_in && transport == TR_REC)
        else $error("Record strobe while playing did not punch in");
    rec_start_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        (accept && cmd == CMD_RSTROBE && transport == TR_STOP) |=> transport == TR_REC && !punch_in)
        else $error("Record strobe while stopped did not record");
    punch_out_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        (accept && cmd == CMD_REXIT && transport != TR_REC) |=> $stable(transport) && !punch_out)
        else $error("Record exit changed transport when not recording");
    slave_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R4
        !slave_mode |=> !punch_in && !punch_out && !field_we)
        else $error("Action taken while not slave");
    stop_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        (accept && cmd == CMD_STOP) |=> transport == TR_STOP)
        else $error("Stop command did not halt");
    play_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        (accept && (cmd == CMD_PLAY || cmd == CMD_DPLAY)) |=> transport == TR_PLAY)
        else $error("Play command did not start playback");
    wind_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R10
        (accept && cmd == CMD_FFWD) |=> transport == TR_FFWD)
        else $error("Fast forward not started");
    rew_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R12
        (accept && cmd == CMD_REW) |=> transport == TR_REW)
        else $error("Rewind not started");
    mreset_cmd_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R17
        (accept && cmd == CMD_MRESET) |=> transport == TR_STOP)
        else $error("Machine control reset not applied");
    sys_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        (rx_valid && rx_data == SYS_RESET) |=> running_status == 8'h00 && rx_st == RX_IDLE)
        else $error("System reset did not clear receiver");
endmodule : mtc_parser
`default_nettype wire

// [design/mtc_pkg.sv]
// Package for the machine control transport parser.
// Assumes a byte-wide receive and transmit path, one byte per strobe.
package mtc_pkg;
    localparam logic [7:0] SYX_START = 8'hF0;
    localparam logic [7:0] SYX_END = 8'hF7;
    localparam logic [7:0] RT_UNIV_ID = 8'h7F;
    localparam logic [7:0] ALL_CALL = 8'h7F;
    localparam logic [7:0] MCC_SUB_ID = 8'h06;
    localparam logic [7:0] SYS_RESET = 8'hFF;
    localparam logic [7:0] ACT_SENSE = 8'hFE;
    localparam logic [7:0] RT_FIRST = 8'hF8;
    localparam logic [7:0] CMD_STOP = 8'h01;
    localparam logic [7:0] CMD_PLAY = 8'h02;
    localparam logic [7:0] CMD_DPLAY = 8'h03;
    localparam logic [7:0] CMD_FFWD = 8'h04;
    localparam logic [7:0] CMD_REW = 8'h05;
    localparam logic [7:0] CMD_RSTROBE = 8'h06;
    localparam logic [7:0] CMD_REXIT = 8'h07;
    localparam logic [7:0] CMD_MRESET = 8'h0D;
    localparam logic [7:0] CMD_WRITE = 8'h40;
    localparam int CLK_HZ = 20000000;
    localparam int SENSE_MS = 300;
    localparam int SENSE_CYC = (CLK_HZ / 1000) * SENSE_MS;
    localparam int TX_LEN = 6;
    typedef enum logic [2:0] {
        TR_STOP,
        TR_PLAY,
        TR_FFWD,
        TR_REW,
        TR_REC
    } mtc_tr_e;
    typedef enum {
        RX_IDLE,
        RX_UNIV,
        RX_DEV,
        RX_SUB,
        RX_CMD,
        RX_COUNT,
        RX_NAME,
        RX_DATA,
        RX_TAIL,
        RX_SKIP
    } mtc_rx_e;
endpackage : mtc_pkg

// [design/mtc_tx_if.sv]
// Carrier between the parser and its transmit sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface mtc_tx_if;
    logic req;
    logic [7:0] cmd;
    logic busy;
    modport src (output req, output cmd, input busy);
    modport snk (input req, input cmd, output busy);
endinterface : mtc_tx_if
`default_nettype wire

// [design/mtc_tx_seq.sv]
// Transmit sequencer: sends one all-call machine control frame per request.
// Assumes the byte sink accepts a byte in the cycle tx_ready is high.
`timescale 1ns/1ps
`default_nettype none
module mtc_tx_seq
    import mtc_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    mtc_tx_if.snk cmd_port,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready
);
    logic [2:0] idx;
    logic [7:0] cmd;
    logic active;

    assign cmd_port.busy = active;
    assign tx_valid = active;

    always_comb
    begin
        case (idx)
            3'h0: tx_data = SYX_START;
            3'h1: tx_data = RT_UNIV_ID;
            3'h2: tx_data = ALL_CALL;
            3'h3: tx_data = MCC_SUB_ID;
            3'h4: tx_data = cmd;
            default: tx_data = SYX_END;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            active <= 1'b0;
            idx <= 3'h0;
            cmd <= 8'h00;
        end
        else if (!active)
        begin
            if (cmd_port.req)
            begin
                active <= 1'b1;
                idx <= 3'h0;
                cmd <= cmd_port.cmd;
            end
        end
        else if (tx_ready)
        begin
            if (idx == 3'(TX_LEN - 1))
            begin
                active <= 1'b0;
            end
            idx <= idx + 3'h1;
        end
    end

    frame_order_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        (tx_valid && tx_ready && idx == 3'h2) |-> tx_data == ALL_CALL)
        else $error("Transmitted frame not all-call");
    byte_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        (tx_valid && !tx_ready) |=> tx_valid && $stable(tx_data))
        else $error("Offered byte changed before it was taken");
endmodule : mtc_tx_seq
`default_nettype wire

// [sim/mmc_transport_command_parser_tb.sv]
// Self-checking bench for the machine control parser.
// Assumes the far-side model in mtc_far_dev and a short sensing timeout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module mmc_transport_command_parser_tb;
    import mtc_pkg::*;
    localparam int SENS = 50;
    localparam logic [7:0] TXC [7] = '{CMD_STOP, CMD_DPLAY, CMD_FFWD, CMD_REW,
        CMD_FFWD, CMD_REW, CMD_MRESET};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic slave_mode = 1'b1;
    logic [6:0] own_id = 7'h00;
    logic [6:0] keys = 7'h00;
    logic tx_valid, tx_ready, punch_in, punch_out, field_we, rx_reinit;
    logic [7:0] tx_data, running_status;
    logic [6:0] field_name, field_data;
    mtc_tr_e transport;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_pin = 0;
    int n_pout = 0;
    int n_reinit = 0;
    logic [13:0] fw[$];
    logic [7:0] fr[$];

    always #25 core_clk = ~core_clk;

    mtc_parser #(.SENSE_CYCLES(SENS)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
        .rx_valid(rx_valid), .rx_data(rx_data), .slave_mode(slave_mode),
        .own_id(own_id), .key_stop(keys[0]), .key_play(keys[1]), .key_ffwd(keys[2]),
        .key_rew(keys[3]), .shuttle_cue(keys[4]), .shuttle_review(keys[5]),
        .song_loaded(keys[6]), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .transport(transport), .punch_in(punch_in),
        .punch_out(punch_out), .field_we(field_we), .field_name(field_name),
        .field_data(field_data), .rx_reinit(rx_reinit), .running_status(running_status));

    mtc_far_dev u_far (.core_clk(core_clk), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready));

    // Pulses are counted here so checks do not hinge on their exact cycle
    always @(posedge core_clk)
    begin
        n_pin += int'(punch_in);
        n_pout += int'(punch_out);
        n_reinit += int'(rx_reinit);
        if (field_we === 1'b1)
            fw.push_back({field_name, field_data});
    end

    task automatic wrap_up();
        $display("counts: compared=%0d mismatched=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    // Bytes go back to back; the tail leaves room for pulses to be counted
    task automatic send_fr();
        foreach (fr[i])
        begin
            @(negedge core_clk);
            rx_valid = 1'b1;
            rx_data = fr[i];
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        repeat (3) @(negedge core_clk);
        fr.delete();
    endtask : send_fr

    function automatic logic [7:0] pick_id();
        return ($urandom % 2) ? ALL_CALL : {1'b0, own_id};
    endfunction : pick_id

    // A negative punch-in count means punch-in is not judged; punch-out is always checked
    task automatic run(input logic [7:0] id, input logic [7:0] sub, input logic [7:0] cmd,
        input mtc_tr_e tr, input int pin, input int pout);
        int p0;
        int q0;
        p0 = n_pin;
        q0 = n_pout;
        fr = '{SYX_START, RT_UNIV_ID, id, sub, cmd, SYX_END};
        send_fr();
        `CHK(transport, tr)
        if (pin >= 0)
            `CHK(n_pin - p0, pin)
        `CHK(n_pout - q0, pout)
    endtask : run

    task automatic go(input logic [7:0] cmd, input mtc_tr_e tr, input int pin, input int pout);
        run(pick_id(), MCC_SUB_ID, cmd, tr, pin, pout);
    endtask : go

    initial
    begin
        int j;
        int k;
        logic [6:0] nm;
        logic [6:0] dt;
        logic [7:0] fid;
        logic [13:0] ew[$];
        void'($urandom(32'h53f8c497));
        own_id = 7'($urandom % 126);
        fid = {1'b0, own_id ^ 7'h01};
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        `CHK(transport, TR_STOP)
        `CHK(running_status, 8'h00)
        $display("test reset done");
        go(CMD_PLAY, TR_PLAY, -1, 0);
        go(CMD_STOP, TR_STOP, -1, 0);
        go(CMD_DPLAY, TR_PLAY, -1, 0);
        go(CMD_FFWD, TR_FFWD, -1, 0);
        go(CMD_REW, TR_REW, -1, 0);
        go(CMD_STOP, TR_STOP, -1, 0);
        go(CMD_RSTROBE, TR_REC, -1, 0);
        go(CMD_REXIT, TR_PLAY, 0, 1);
        go(CMD_REXIT, TR_PLAY, 0, 0);
        go(CMD_RSTROBE, TR_REC, 1, 0);
        go(CMD_MRESET, TR_STOP, -1, 0);
        go(CMD_REXIT, TR_STOP, 0, 0);
        go(CMD_PLAY, TR_PLAY, -1, 0);
        $display("test commands done");
        run(fid, MCC_SUB_ID, CMD_STOP, TR_PLAY, 0, 0);
        slave_mode = 1'b0;
        run(ALL_CALL, MCC_SUB_ID, CMD_STOP, TR_PLAY, 0, 0);
        slave_mode = 1'b1;
        run(ALL_CALL, MCC_SUB_ID, 8'h08, TR_PLAY, 0, 0);
        run(ALL_CALL, 8'h07, CMD_STOP, TR_PLAY, 0, 0);
        // A status byte after the command must cut the frame; F7 then clears status
        fr = '{SYX_START, RT_UNIV_ID, ALL_CALL, MCC_SUB_ID, CMD_STOP, 8'h90, SYX_END, 8'h90};
        send_fr();
        `CHK(transport, TR_PLAY)
        `CHK(running_status, 8'h90)
        fr = '{SYX_START, RT_UNIV_ID, ALL_CALL, MCC_SUB_ID, RT_FIRST, CMD_STOP, SYX_END};
        send_fr();
        `CHK(transport, TR_STOP)
        $display("test refusals done");
        k = n_reinit;
        fr = '{8'h92, SYS_RESET};
        send_fr();
        `CHK(n_reinit - k, 1)
        `CHK(running_status, 8'h00)
        $display("test system reset done");
        for (int n = 0; n < 4; n++)
        begin
            fw.delete();
            ew.delete();
            fr = '{SYX_START, RT_UNIV_ID, (n == 3) ? fid : pick_id(), MCC_SUB_ID,
                CMD_WRITE, 8'(2 * n)};
            repeat (n)
            begin
                nm = 7'($urandom);
                dt = 7'($urandom);
                fr.push_back({1'b0, nm});
                fr.push_back({1'b0, dt});
                if (n < 3)
                    ew.push_back({nm, dt});
            end
            fr.push_back(SYX_END);
            send_fr();
            `CHK(fw.size(), ew.size())
            foreach (ew[i]) `CHK(fw[i], ew[i])
        end
        $display("test write done");
        fr = '{8'h91, ACT_SENSE};
        k = n_reinit;
        send_fr();
        `CHK(running_status, 8'h91)
        j = 0;
        while (n_reinit == k && j < 4 * SENS)
        begin
            @(negedge core_clk);
            j++;
        end
        `CHK((j + 4 >= SENS - 1) && (j + 4 <= SENS + 3), 1'b1)
        `CHK(running_status, 8'h00)
        if (j >= 4 * SENS)
            wrap_up();
        $display("test sensing done");
        for (int i = 0; i < 7; i++)
        begin
            u_far.got.delete();
            u_far.slow = 1'($urandom % 2);
            keys[i] = 1'b1;
            j = 0;
            while (u_far.got.size() < 6 && j < 400)
            begin
                @(negedge core_clk);
                j++;
            end
            keys[i] = 1'b0;
            repeat (12) @(negedge core_clk);
            `CHK(u_far.got.size(), 6)
            fr = '{SYX_START, RT_UNIV_ID, ALL_CALL, MCC_SUB_ID, TXC[i], SYX_END};
            foreach (fr[b]) `CHK(u_far.got[b], fr[b])
            fr.delete();
            if (j >= 400)
                wrap_up();
        end
        $display("test transmit done");
        wrap_up();
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        wrap_up();
    end
endmodule : mmc_transport_command_parser_tb
`default_nettype wire

// [sim/mtc_far_dev.sv]
// Far-side MIDI device model: takes the parser's transmitted byte stream.
// Assumes a byte passes at a rising edge where tx_valid and tx_ready are high.
`timescale 1ns/1ps
`default_nettype none
module mtc_far_dev
(
    input wire logic core_clk,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] got[$];
    bit slow = 1'b0;

    // Random stalls prove that each offered byte stands until taken
    always @(negedge core_clk)
        tx_ready <= slow ? 1'($urandom % 2) : 1'b1;

    // every passed byte kept in arrival order for the bench to judge
    always @(posedge core_clk)
        if (tx_valid && tx_ready)
            got.push_back(tx_data);
endmodule : mtc_far_dev
`default_nettype wire
